// file: core/io_exec_core.sv
// port i/o instruction executor with axi4-lite register access
// Overview of operation
// (RULE_01) port number drives address bits 7..0
// (RULE_02) register B drives address bits 15..8
// (RULE_03) peripheral supplies one byte on input
// (RULE_04) ED AA: port to memory, dec B, pointer
// (RULE_05) single input: 4 cycles, 16 states
// (RULE_06) single input: Z if B-1 zero, N set
// (RULE_07) ED BA: repeat, rewind counter by two
// (RULE_08) interrupts, two refreshes between iterations
// (RULE_09) B zero at start moves 256 bytes
// (RULE_10) repeat 21 states, final iteration 16
// (RULE_11) repeat end: Z and N set
// (RULE_12) D3 n: n low, accumulator high, write
// (RULE_13) D3 n: 11 states, flags untouched
// (RULE_14) ED 01rrr001: register to port C
// (RULE_15) register output: 12 states, flags untouched
// (RULE_16) ED B2: repeat with pointer incremented
// (RULE_17) counter and pointer wrap silently
// (RULE_18) write and address use pre-update values
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
module io_exec_core #(
   parameter int BUF_DEPTH = 2
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output io_exec_pkg::port_bus_type port_bus,
   input wire logic [7:0] port_din,
   input wire logic port_din_valid,
   output logic port_din_ready,
   output io_exec_pkg::mem_wr_type mem_wr,
   output logic mem_wr_valid,
   input wire logic mem_wr_ready,
   input wire logic int_req,
   output logic int_ack,
   output logic refresh
);
   localparam int CW = $clog2(BUF_DEPTH + 1);
   localparam logic [CW-1:0] DEPTH_C = CW'(BUF_DEPTH);

   if (BUF_DEPTH < 2 || BUF_DEPTH > 8) begin : g_depth_check
      $error("BUF_DEPTH must lie between 2 and 8");
   end

   typedef struct packed {
      io_exec_pkg::state_type st;
      io_exec_pkg::kind_type kind;
      logic [2:0] t;
      logic [3:0] mcyc;
      logic [4:0] tst;
      logic [3:0] last_m;
      logic [4:0] last_t;
      logic [7:0] b, c, d, e, h, l, a, f;
      logic [15:0] pc;
      logic [7:0] op1;
      logic intr, illegal;
      logic [BUF_DEPTH-1:0][23:0] fifo;
      logic [CW-1:0] cnt;
      logic buf_valid, in_ready;
      io_exec_pkg::port_bus_type port;
      logic refresh, int_ack;
      logic aw_have, w_have;
      logic [7:0] aw_l;
      logic [31:0] wd_l;
      logic [3:0] ws_l;
      logic awready, wready, bvalid, arready, rvalid;
      logic [1:0] bresp, rresp;
      logic [31:0] rdata;
   } state_reg_type;

   state_reg_type s_reg, s_next;

   function automatic logic [2:0] mlen(io_exec_pkg::state_type st,
                                       io_exec_pkg::kind_type k);
      logic [2:0] r;
      r = io_exec_pkg::T_FETCH;
      case (st)
         io_exec_pkg::S_OPER: begin
            r = (k == io_exec_pkg::K_OUTN) ? io_exec_pkg::T_OUTN_OPER :
                (k == io_exec_pkg::K_OUTC) ? io_exec_pkg::T_OUTC_OPER :
                io_exec_pkg::T_BLK_OPER; // RULE_05 RULE_13 RULE_15
         end
         io_exec_pkg::S_PORT: begin
            r = (k == io_exec_pkg::K_OUTN) ? io_exec_pkg::T_OUTN_PORT :
                (k == io_exec_pkg::K_OUTC) ? io_exec_pkg::T_OUTC_PORT :
                io_exec_pkg::T_BLK_PORT;
         end
         io_exec_pkg::S_MEMW: r = io_exec_pkg::T_BLK_MEMW;
         io_exec_pkg::S_BACK: r = io_exec_pkg::T_BLK_BACK; // RULE_10
         default: r = io_exec_pkg::T_FETCH;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] src_reg(state_reg_type s, logic [2:0] sel);
      logic [7:0] r;
      r = s.a;
      case (sel) // RULE_14
         io_exec_pkg::SRC_B: r = s.b;
         io_exec_pkg::SRC_C: r = s.c;
         io_exec_pkg::SRC_D: r = s.d;
         io_exec_pkg::SRC_E: r = s.e;
         io_exec_pkg::SRC_H: r = s.h;
         io_exec_pkg::SRC_L: r = s.l;
         default: r = s.a;
      endcase
      return r;
   endfunction

   function automatic logic [7:0] merge8(logic [7:0] old, logic [7:0] nw,
                                         logic en);
      return en ? nw : old;
   endfunction

   always_comb begin
      logic pop, push, is_in;
      logic [7:0] b_dec;
      logic [15:0] hl, hl_upd;
      logic [23:0] push_word;
      logic [CW-1:0] cnt_pop;
      logic [31:0] rd;
      s_next = s_reg;
      s_next.refresh = 1'b0;
      s_next.int_ack = 1'b0;
      push = 1'b0;
      pop = 1'b0;
      cnt_pop = '0;
      rd = 32'h0;
      hl = {s_reg.h, s_reg.l};
      push_word = {hl, port_din}; // RULE_18
      is_in = (s_reg.kind != io_exec_pkg::K_OUTN) &&
              (s_reg.kind != io_exec_pkg::K_OUTC);
      b_dec = s_reg.b - 8'h01; // RULE_09 RULE_17
      hl_upd = (s_reg.kind == io_exec_pkg::K_INPUT_INCREMENTING_REPEAT) ?
               hl + 16'h0001 : hl - 16'h0001; // RULE_16 RULE_17

      // sequencer: one aclk per clock state
      if (s_reg.st != io_exec_pkg::S_IDLE) begin
         s_next.t = s_reg.t - 3'h1;
         s_next.tst = s_reg.tst + 5'h01;
      end
      unique case (s_reg.st)
         io_exec_pkg::S_IDLE: begin
         end
         io_exec_pkg::S_FETCH: begin
            if (s_reg.t == 3'h0) begin
               s_next.st = io_exec_pkg::S_OPER;
               s_next.t = mlen(io_exec_pkg::S_OPER, s_reg.kind) - 3'h1;
               s_next.mcyc = s_reg.mcyc + 4'h1;
            end
         end
         io_exec_pkg::S_OPER: begin
            if (s_reg.t == 3'h0) begin
               s_next.st = io_exec_pkg::S_PORT;
               s_next.t = mlen(io_exec_pkg::S_PORT, s_reg.kind) - 3'h1;
               s_next.mcyc = s_reg.mcyc + 4'h1;
               s_next.pc = s_reg.pc + io_exec_pkg::PC_STEP;
               if (s_reg.kind == io_exec_pkg::K_OUTN) begin
                  s_next.port.addr = {s_reg.a, s_reg.op1}; // RULE_01 RULE_12
                  s_next.port.dout = s_reg.a; // RULE_12
                  s_next.port.wr = 1'b1;
               end else begin
                  s_next.port.addr = {s_reg.b, s_reg.c}; // RULE_01 RULE_02
                  s_next.port.dout = src_reg(s_reg, s_reg.op1[5:3]);
                  s_next.port.wr = !is_in; // RULE_14
                  s_next.port.rd = is_in;
               end
            end
         end
         io_exec_pkg::S_PORT: begin
            if (s_reg.t == 3'h0) begin
               if (!is_in) begin
                  // outputs end here, flags untouched
                  s_next.port.wr = 1'b0; // RULE_13 RULE_15
                  s_next.st = io_exec_pkg::S_IDLE;
                  s_next.last_m = s_reg.mcyc + 4'h1;
                  s_next.last_t = s_reg.tst + 5'h01;
               end else if (port_din_valid && s_reg.in_ready) begin
                  push = 1'b1; // RULE_03 RULE_04
                  s_next.port.rd = 1'b0;
                  s_next.st = io_exec_pkg::S_MEMW;
                  s_next.t = mlen(io_exec_pkg::S_MEMW, s_reg.kind) - 3'h1;
                  s_next.mcyc = s_reg.mcyc + 4'h1;
               end else begin
                  // stall holds the state count, not a documented state
                  s_next.t = 3'h0;
                  s_next.tst = s_reg.tst;
               end
            end
         end
         io_exec_pkg::S_MEMW: begin
            if (s_reg.t == 3'h0) begin
               s_next.b = b_dec; // RULE_04
               {s_next.h, s_next.l} = hl_upd;
               s_next.f[io_exec_pkg::FLAG_N] = 1'b1; // RULE_06 RULE_11
               s_next.f[io_exec_pkg::FLAG_Z] = (b_dec == 8'h00); // RULE_06
               if (s_reg.kind != io_exec_pkg::K_IND && b_dec != 8'h00) begin
                  s_next.st = io_exec_pkg::S_BACK;
                  s_next.t = mlen(io_exec_pkg::S_BACK, s_reg.kind) - 3'h1;
                  s_next.mcyc = s_reg.mcyc + 4'h1;
                  s_next.pc = s_reg.pc - io_exec_pkg::PC_STEP; // RULE_07
               end else begin
                  s_next.st = io_exec_pkg::S_IDLE; // RULE_05 RULE_10
                  s_next.last_m = s_reg.mcyc + 4'h1;
                  s_next.last_t = s_reg.tst + 5'h01;
               end
            end
         end
         io_exec_pkg::S_BACK: begin
            s_next.refresh = (s_reg.t >= io_exec_pkg::T_REFRESH_FROM); // RULE_08
            if (s_reg.t == 3'h0) begin
               s_next.last_m = s_reg.mcyc + 4'h1; // RULE_10
               s_next.last_t = s_reg.tst + 5'h01;
               s_next.mcyc = 4'h0;
               s_next.tst = 5'h00;
               s_next.t = io_exec_pkg::T_FETCH - 3'h1;
               if (int_req) begin
                  // counter already rewound, so the loop resumes later
                  s_next.st = io_exec_pkg::S_IDLE; // RULE_08
                  s_next.intr = 1'b1;
                  s_next.int_ack = 1'b1;
               end else begin
                  s_next.st = io_exec_pkg::S_FETCH; // RULE_07
               end
            end
         end
      endcase

      // BUF_DEPTH-entry shift buffer toward memory, head always at slot 0
      pop = s_reg.buf_valid && mem_wr_ready;
      cnt_pop = s_reg.cnt - CW'(pop);
      for (int i = 0; i < BUF_DEPTH; i++) begin
         if (pop) begin
            s_next.fifo[i] = (i + 1 < BUF_DEPTH) ? s_reg.fifo[i+1] : 24'h0;
         end
      end
      if (push) begin
         s_next.fifo[cnt_pop] = push_word;
      end
      s_next.cnt = cnt_pop + CW'(push);
      s_next.buf_valid = (s_next.cnt != '0);
      s_next.in_ready = (s_next.cnt < DEPTH_C);

      // axi write path
      if (awvalid && s_reg.awready) begin
         s_next.aw_have = 1'b1;
         s_next.aw_l = awaddr;
      end
      if (wvalid && s_reg.wready) begin
         s_next.w_have = 1'b1;
         s_next.wd_l = wdata;
         s_next.ws_l = wstrb;
      end
      if (s_reg.bvalid && bready) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
         s_next.aw_have = 1'b0;
         s_next.w_have = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = io_exec_pkg::RESP_OKAY;
         if (s_reg.st != io_exec_pkg::S_IDLE &&
             s_reg.aw_l != io_exec_pkg::OFS_STATUS) begin
            // no register changes under a running instruction
            s_next.bresp = io_exec_pkg::RESP_SLVERR;
         end else begin
            case (s_reg.aw_l)
               io_exec_pkg::OFS_CMD: begin
                  s_next.op1 = s_reg.wd_l[15:8];
                  s_next.intr = 1'b0;
                  s_next.illegal = 1'b0;
                  s_next.st = io_exec_pkg::S_FETCH;
                  s_next.t = io_exec_pkg::T_FETCH - 3'h1;
                  s_next.mcyc = 4'h0;
                  s_next.tst = 5'h00;
                  if (s_reg.wd_l[7:0] == io_exec_pkg::OP_OUT_N) begin
                     s_next.kind = io_exec_pkg::K_OUTN;
                  end else if (s_reg.wd_l[7:0] != io_exec_pkg::OP_PREFIX) begin
                     s_next.st = io_exec_pkg::S_IDLE;
                     s_next.illegal = 1'b1;
                  end else if (s_reg.wd_l[15:8] == io_exec_pkg::OP_IND) begin
                     s_next.kind = io_exec_pkg::K_IND;
                  end else if (s_reg.wd_l[15:8] == io_exec_pkg::OP_INPUT_DECREMENTING_REPEAT) begin
                     s_next.kind = io_exec_pkg::K_INPUT_DECREMENTING_REPEAT;
                  end else if (s_reg.wd_l[15:8] == io_exec_pkg::OP_INPUT_INCREMENTING_REPEAT) begin
                     s_next.kind = io_exec_pkg::K_INPUT_INCREMENTING_REPEAT;
                  end else if ((s_reg.wd_l[15:8] & io_exec_pkg::OUT_C_MASK) ==
                               io_exec_pkg::OUT_C_PAT &&
                               s_reg.wd_l[13:11] != io_exec_pkg::SRC_HOLE) begin
                     s_next.kind = io_exec_pkg::K_OUTC;
                  end else begin
                     s_next.st = io_exec_pkg::S_IDLE;
                     s_next.illegal = 1'b1;
                  end
               end
               io_exec_pkg::OFS_STATUS: begin
               end
               io_exec_pkg::OFS_BC: begin
                  s_next.b = merge8(s_reg.b, s_reg.wd_l[15:8], s_reg.ws_l[1]);
                  s_next.c = merge8(s_reg.c, s_reg.wd_l[7:0], s_reg.ws_l[0]);
               end
               io_exec_pkg::OFS_DE: begin
                  s_next.d = merge8(s_reg.d, s_reg.wd_l[15:8], s_reg.ws_l[1]);
                  s_next.e = merge8(s_reg.e, s_reg.wd_l[7:0], s_reg.ws_l[0]);
               end
               io_exec_pkg::OFS_HL: begin
                  s_next.h = merge8(s_reg.h, s_reg.wd_l[15:8], s_reg.ws_l[1]);
                  s_next.l = merge8(s_reg.l, s_reg.wd_l[7:0], s_reg.ws_l[0]);
               end
               io_exec_pkg::OFS_AF: begin
                  s_next.a = merge8(s_reg.a, s_reg.wd_l[15:8], s_reg.ws_l[1]);
                  s_next.f = merge8(s_reg.f, s_reg.wd_l[7:0], s_reg.ws_l[0]);
               end
               io_exec_pkg::OFS_PC: begin
                  s_next.pc[15:8] = merge8(s_reg.pc[15:8], s_reg.wd_l[15:8],
                                           s_reg.ws_l[1]);
                  s_next.pc[7:0] = merge8(s_reg.pc[7:0], s_reg.wd_l[7:0],
                                          s_reg.ws_l[0]);
               end
               default: s_next.bresp = io_exec_pkg::RESP_SLVERR;
            endcase
         end
      end
      s_next.awready = !s_next.aw_have;
      s_next.wready = !s_next.w_have;

      // axi read path, data sampled at the taking edge
      rd = 32'h0;
      case (araddr)
         io_exec_pkg::OFS_CMD: rd = {24'h0, s_reg.op1};
         io_exec_pkg::OFS_STATUS: begin
            rd[io_exec_pkg::ST_BUSY] = (s_reg.st != io_exec_pkg::S_IDLE);
            rd[io_exec_pkg::ST_INTR] = s_reg.intr;
            rd[io_exec_pkg::ST_ILLEGAL] = s_reg.illegal;
            rd[io_exec_pkg::ST_BUF] = s_reg.buf_valid;
            rd[io_exec_pkg::ST_MCYC_LSB +: 4] = s_reg.last_m;
            rd[io_exec_pkg::ST_TST_LSB +: 5] = s_reg.last_t;
         end
         io_exec_pkg::OFS_BC: rd = {16'h0, s_reg.b, s_reg.c};
         io_exec_pkg::OFS_DE: rd = {16'h0, s_reg.d, s_reg.e};
         io_exec_pkg::OFS_HL: rd = {16'h0, s_reg.h, s_reg.l};
         io_exec_pkg::OFS_AF: rd = {16'h0, s_reg.a, s_reg.f};
         io_exec_pkg::OFS_PC: rd = {16'h0, s_reg.pc};
         default: rd = 32'h0;
      endcase
      if (s_reg.rvalid && rready) begin
         s_next.rvalid = 1'b0;
      end
      if (arvalid && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = rd;
         s_next.rresp = (rd == 32'h0 && araddr != io_exec_pkg::OFS_CMD &&
                         araddr != io_exec_pkg::OFS_STATUS &&
                         araddr != io_exec_pkg::OFS_BC &&
                         araddr != io_exec_pkg::OFS_DE &&
                         araddr != io_exec_pkg::OFS_HL &&
                         araddr != io_exec_pkg::OFS_AF &&
                         araddr != io_exec_pkg::OFS_PC) ?
                        io_exec_pkg::RESP_SLVERR : io_exec_pkg::RESP_OKAY;
      end
      s_next.arready = !s_next.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign awready = s_reg.awready;
   assign wready = s_reg.wready;
   assign bvalid = s_reg.bvalid;
   assign bresp = s_reg.bresp;
   assign arready = s_reg.arready;
   assign rvalid = s_reg.rvalid;
   assign rdata = s_reg.rdata;
   assign rresp = s_reg.rresp;
   assign port_bus = s_reg.port;
   assign port_din_ready = s_reg.in_ready;
   assign mem_wr = s_reg.fifo[0];
   assign mem_wr_valid = s_reg.buf_valid;
   assign int_ack = s_reg.int_ack;
   assign refresh = s_reg.refresh;
endmodule

// file: inc/io_exec_pkg.sv
// constants and carrier types for the port i/o instruction executor
package io_exec_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CMD = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_BC = 8'h08;
   localparam logic [7:0] OFS_DE = 8'h0c;
   localparam logic [7:0] OFS_HL = 8'h10;
   localparam logic [7:0] OFS_AF = 8'h14;
   localparam logic [7:0] OFS_PC = 8'h18;
   // status field positions
   localparam int ST_BUSY = 0;
   localparam int ST_INTR = 1;
   localparam int ST_ILLEGAL = 2;
   localparam int ST_BUF = 3;
   localparam int ST_MCYC_LSB = 8;
   localparam int ST_TST_LSB = 16;
   // flag positions
   localparam int FLAG_Z = 6;
   localparam int FLAG_N = 1;
   // opcodes
   localparam logic [7:0] OP_PREFIX = 8'hed;
   localparam logic [7:0] OP_IND = 8'haa;
   localparam logic [7:0] OP_INPUT_DECREMENTING_REPEAT = 8'hba;
   localparam logic [7:0] OP_INPUT_INCREMENTING_REPEAT = 8'hb2;
   localparam logic [7:0] OP_OUT_N = 8'hd3;
   localparam logic [7:0] OUT_C_MASK = 8'hc7;
   localparam logic [7:0] OUT_C_PAT = 8'h41;
   localparam logic [2:0] SRC_HOLE = 3'h6;
   localparam logic [2:0] SRC_B = 3'h0;
   localparam logic [2:0] SRC_C = 3'h1;
   localparam logic [2:0] SRC_D = 3'h2;
   localparam logic [2:0] SRC_E = 3'h3;
   localparam logic [2:0] SRC_H = 3'h4;
   localparam logic [2:0] SRC_L = 3'h5;
   localparam logic [2:0] SRC_A = 3'h7;
   // clock states per machine cycle, one state per aclk
   localparam logic [2:0] T_FETCH = 3'h4;
   localparam logic [2:0] T_BLK_OPER = 3'h5;
   localparam logic [2:0] T_BLK_PORT = 3'h3;
   localparam logic [2:0] T_BLK_MEMW = 3'h4;
   localparam logic [2:0] T_BLK_BACK = 3'h5;
   localparam logic [2:0] T_OUTN_OPER = 3'h3;
   localparam logic [2:0] T_OUTN_PORT = 3'h4;
   localparam logic [2:0] T_OUTC_OPER = 3'h4;
   localparam logic [2:0] T_OUTC_PORT = 3'h4;
   localparam logic [2:0] T_REFRESH_FROM = 3'h3;
   localparam logic [15:0] PC_STEP = 16'h0002;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_FETCH = 3'h1,
      S_OPER = 3'h3,
      S_PORT = 3'h2,
      S_MEMW = 3'h6,
      S_BACK = 3'h7
   } state_type;

   typedef enum logic [2:0] {
      K_IND = 3'h0,
      K_INPUT_DECREMENTING_REPEAT = 3'h1,
      K_INPUT_INCREMENTING_REPEAT = 3'h2,
      K_OUTN = 3'h3,
      K_OUTC = 3'h4
   } kind_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] dout;
      logic rd;
      logic wr;
   } port_bus_type;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } mem_wr_type;
endpackage

// file: tb/io_exec_properties.sv
// port-side checks for the port i/o executor
module io_exec_properties (
   input wire logic aclk,
   input wire logic aresetn,
   input wire io_exec_pkg::port_bus_type port_bus,
   input wire logic port_din_valid,
   input wire logic port_din_ready,
   input wire io_exec_pkg::mem_wr_type mem_wr,
   input wire logic mem_wr_valid,
   input wire logic mem_wr_ready,
   input wire logic int_ack,
   input wire logic refresh
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   mem_hold_a: assert property (mem_wr_valid && !mem_wr_ready |=>
      mem_wr_valid && $stable(mem_wr)) else $error("mem word lost");
   refresh_pair_a: assert property ($rose(refresh) |->
      refresh[*2] ##1 !refresh) else $error("refresh not two cycles");
   out_len_a: assert property ($rose(port_bus.wr) |->
      port_bus.wr[*4] ##1 !port_bus.wr) else $error("port write length");
   bus_excl_a: assert property (!(port_bus.rd && port_bus.wr) &&
      !(refresh && (port_bus.rd || port_bus.wr))) else $error("bus clash");
   addr_hold_a: assert property (port_bus.rd && !port_din_valid |=>
      port_bus.rd && $stable(port_bus.addr)) else $error("port rd moved");
   ack_pulse_a: assert property (int_ack |=> !int_ack)
      else $error("ack too long");
   take_mem_a: assert property ($fell(port_bus.rd) |-> mem_wr_valid)
      else $error("byte not buffered");
   out_hold_a: assert property (port_bus.wr && $past(port_bus.wr) |->
      $stable(port_bus.addr) && $stable(port_bus.dout)) else $error("out moved");
   cover property ($rose(refresh));
   cover property (int_ack);
   cover property (port_bus.rd && !port_din_ready);
endmodule
bind io_exec_core io_exec_properties io_exec_properties_i (.aclk(aclk),
   .aresetn(aresetn), .port_bus(port_bus), .port_din_valid(port_din_valid),
   .port_din_ready(port_din_ready), .mem_wr(mem_wr),
   .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
   .int_ack(int_ack), .refresh(refresh));

// file: tb/io_port_partner.sv
// peripheral and memory stand-in on the far side of the executor
module io_port_partner (
   input wire logic aclk,
   input wire logic aresetn,
   input wire io_exec_pkg::port_bus_type port_bus,
   input wire logic [1:0] stall,
   output logic [7:0] port_din,
   output logic port_din_valid,
   output logic mem_wr_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] dat;
   // offer held until rd drops: the take edge is the design's choice
   always_ff @(posedge aclk) begin
      if (!aresetn || !port_bus.rd) begin
         port_din_valid <= 1'b0;
      end else if (!stall[0]) begin
         port_din_valid <= 1'b1;
      end
      if (!port_din_valid) begin
         dat <= port_bus.addr[15:8] ^ 8'h5a;
      end
   end
   // released bus shows the inverted byte, never a stale copy
   assign port_din = port_din_valid ? dat : ~dat;
   assign mem_wr_ready = !stall[1];
endmodule

// file: tb/tb_top.sv
// self-checking bench for the port i/o executor
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic aclk = 0, aresetn = 0, int_req = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, v;
   logic awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
   logic awready, wready, bvalid, arready, rvalid, refresh, int_ack, pw;
   logic [1:0] bresp, rresp, stall = 0, r;
   logic [7:0] port_din;
   logic port_din_valid, port_din_ready, mem_wr_valid, mem_wr_ready;
   io_exec_pkg::port_bus_type port_bus;
   io_exec_pkg::mem_wr_type mem_wr;
   logic [15:0] seed = 16'h000b, rs = 16'h000b;
   logic [31:0] mq[$], pq[$];
   int rg[8];
   int pc, k, cyc, hend, slow, nref, nack, nfull, miscompares, comparisons;
   io_exec_core io_exec_core_i (.aclk, .aresetn, .awaddr, .awvalid,
      .awready, .wdata, .wstrb(4'h3), .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
      .port_bus, .port_din, .port_din_valid, .port_din_ready, .mem_wr,
      .mem_wr_valid, .mem_wr_ready, .int_req, .int_ack, .refresh);
   io_port_partner io_port_partner_i (.aclk, .aresetn, .port_bus, .stall,
      .port_din, .port_din_valid, .mem_wr_ready);
   always #2.5 aclk = ~aclk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   always @(posedge aclk) begin
      seed <= lfsr(seed);
      cyc <= cyc + 1;
      stall <= {cyc < hend || (slow && seed[3]), slow && seed[7]};
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, s, e);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic hang;
      miscompares++;
      tally_and_finish;
   endtask
   // sampled at the falling edge, acted on at the next rising edge
   always @(negedge aclk) begin
      if (mem_wr_valid && mem_wr_ready) chk(mem_wr, mq.pop_front());
      if (port_bus.wr && !pw)
         chk({port_bus.addr, port_bus.dout}, pq.pop_front());
      pw = port_bus.wr;
      nref += refresh;
      nack += int_ack;
      nfull += port_bus.rd && !port_din_ready;
   end
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er);
      logic ta, tw, done = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      for (int n = 0; n < 99 && !done; n++) begin
         @(negedge aclk);
         ta = awready;
         tw = wready;
         done = bvalid;
         if (done) chk(bresp, er);
         @(posedge aclk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      if (!done) hang;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] rr);
      logic ta, done = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      for (int n = 0; n < 99 && !done; n++) begin
         @(negedge aclk);
         ta = arready;
         done = rvalid;
         d = rdata;
         rr = rresp;
         @(posedge aclk);
         if (ta) arvalid <= 1'b0;
      end
      if (!done) hang;
   endtask
   task automatic tcase(input logic [7:0] op, a, input int b, irq, mode);
      int i, hl, it = 0, ill = 0, intr = 0, lt = 12, lm = 3;
      int ex[4];
      logic [31:0] m;
      for (i = 0; i < 8; i++) begin
         rs = lfsr(rs);
         rg[i] = rs[7:0];
      end
      rg[0] = b;
      pc = lfsr(rs);
      axw(8'h08, rg[0] * 256 + rg[1], 0);
      axw(8'h0c, rg[2] * 256 + rg[3], 0);
      axw(8'h10, rg[4] * 256 + rg[5], 0);
      axw(8'h14, rg[7] * 256 + rg[6], 0);
      axw(8'h18, pc, 0);
      if (op == 8'hd3) begin
         pq.push_back({rg[7][7:0], a, rg[7][7:0]});
         lt = 11;
      end else if (a[2:0] == 3'h1) begin
         ill = a[5:3] == 3'h6;
         if (!ill) pq.push_back({rg[0][7:0], rg[1][7:0], rg[a[5:3]][7:0]});
      end else begin
         do begin
            hl = rg[4] * 256 + rg[5];
            mq.push_back({hl[15:0], rg[0][7:0] ^ 8'h5a});
            hl = (hl + (a == 8'hb2 ? 1 : 65535)) % 65536;
            rg[4] = hl / 256;
            rg[5] = hl % 256;
            rg[0] = (rg[0] + 255) % 256;
            rg[6] = rg[6] & 8'hbd | 2 | (rg[0] == 0) * 64;
            it++;
         end while (a != 8'haa && rg[0] != 0 && !irq);
         intr = a != 8'haa && rg[0] != 0;
         lt = intr ? 21 : 16;
         lm = intr ? 5 : 4;
      end
      if (!intr) pc = (pc + 2) % 65536;
      int_req <= irq;
      slow = mode == 1;
      hend = mode == 2 ? cyc + 150 : 0;
      nref = 0;
      nack = 0;
      nfull = 0;
      axw(8'h00, {a, op}, 0);
      if (!ill) axw(8'h0c, 0, 2); // busy refuses register writes
      v = 1;
      for (i = 0; i < 3000 && v[0]; i++) axr(8'h04, v, r);
      if (v[0]) hang;
      int_req <= 0;
      m = ill ? 32'h7 : 32'h1f0f07;
      chk(v & m, (lt << 16 | lm << 8 | ill << 2 | intr << 1) & m);
      for (i = 0; i < 200 && mq.size() + pq.size(); i++) @(posedge aclk);
      slow = 0;
      chk(mq.size() + pq.size(), 0);
      chk(nref, intr ? 2 : it > 1 ? 2 * it - 2 : 0);
      chk(nack, intr);
      if (mode == 2) chk(nfull > 0, 1);
      ex = '{rg[0] * 256 + rg[1], rg[4] * 256 + rg[5], rg[7] * 256 + rg[6], pc};
      for (i = 0; i < 4 && !ill; i++) begin
         axr(i ? 8'h0c + 4 * i : 8'h08, v, r);
         chk({r, v[15:0]}, ex[i]);
      end
      $display("test %h %h done", op, a);
   endtask
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (k = 1; k < 7; k++) begin
         axr(4 * k, v, r);
         chk({r, v[29:0]}, 0);
      end
      axr(8'h40, v, r);
      chk({r, v[29:0]}, {2'h2, 30'h0});
      axw(8'h40, 1, 2);
      tcase(8'hed, 8'haa, 8'h10, 0, 0);
      tcase(8'hed, 8'haa, 1, 0, 1);
      tcase(8'hed, 8'hba, 3, 0, 1);
      tcase(8'hed, 8'hba, 3, 0, 2);
      tcase(8'hed, 8'hb2, 2, 0, 1);
      tcase(8'hed, 8'hba, 0, 0, 0);
      tcase(8'hed, 8'hba, 5, 1, 0);
      tcase(8'hd3, 8'h01, 7, 0, 1);
      for (k = 0; k < 8; k++) tcase(8'hed, 8'h41 | k << 3, 9, 0, k % 2);
      tally_and_finish;
   end
endmodule
